/* core/efrs_map.vh */
// constants of the earth-fault recorder settings and records block
`ifndef EFRS_MAP_VH
`define EFRS_MAP_VH

// recorded register address codes, also shown as the leftmost display digit
`define EFRS_REG_CTRL      4'h0
`define EFRS_REG_MAXCUR    4'h1
`define EFRS_REG_LOWCNT    4'h2
`define EFRS_REG_HIGHCNT   4'h3
`define EFRS_REG_LOWDUR    4'h4
`define EFRS_REG_HIGHDUR   4'h5
`define EFRS_REG_COMM      4'hA

// display digit codes
`define EFRS_DIGIT_BLANK   4'hF
`define EFRS_DIGIT_ZERO    4'h0

// indicator reset mode bit positions and factory value
`define EFRS_IND_LOW_START  0
`define EFRS_IND_LOW_OP     1
`define EFRS_IND_HIGH_START 2
`define EFRS_IND_HIGH_OP    3
`define EFRS_IND_RESET      4'hA

// function switch positions of the high-set time range pair
`define EFRS_FSW_HTIME_LO  6
`define EFRS_FSW_HTIME_HI  7

// high-set time unit per range, in ms per knob step
`define EFRS_HUNIT_SHORT_MS 17'h0000A
`define EFRS_HUNIT_MID_MS   17'h00064
`define EFRS_HUNIT_LONG_MS  17'h003E8

// serial rate codes: 300, 1200, 2400, 4800, 9600 Bd
`define EFRS_RATE_300      3'h0
`define EFRS_RATE_1200     3'h1
`define EFRS_RATE_2400     3'h2
`define EFRS_RATE_4800     3'h3
`define EFRS_RATE_9600     3'h4
`define EFRS_RATE_RESET    3'h4

// software write selectors
`define EFRS_SEL_INDICATOR 2'h0
`define EFRS_SEL_ADDRESS   2'h1
`define EFRS_SEL_RATE      2'h2
`define EFRS_SEL_PASSWORD  2'h3
`define EFRS_SUBMENU_IND   2'h3

// reset values of the communication settings
`define EFRS_ADDR_RESET    8'h01
`define EFRS_PW_RESET      8'h00

// timing: clock rate, 1 ms record tick, scroll step of the interruption counter
`define EFRS_CLK_HZ        40000000
`define EFRS_TICK_MS       1
`define EFRS_SCROLL_MS     10
`define EFRS_PCT_STEP      17'h00064
`define EFRS_PCT_TRIP      8'h64
`define EFRS_PCT_RUN_MAX   8'h63

`endif

/* core/efrs_top.v */
// settings decode, recorded data and display of a two-stage earth-fault recorder
// Function
// R1 - high-set time range from two switches
// R2 - each stage indicator self or manual reset
// R3 - indicator setting weights 1,2,4,8 mean manual
// R4 - factory indicator setting is 10
// R5 - board switches route start and control signals
// R6 - leftmost digit address, three digits value
// R7 - maximum current follows peaks and operation
// R8 - count low-set starts 0 to 255
// R9 - count high-set starts 0 to 255
// R10 - low-set start duration percent, trip gives 100
// R11 - high-set start duration percent, trip gives 100
// R12 - rightmost control digit encodes blocking state
// R13 - middle digit zero, third digit remote reset
// R14 - trip test entered from control register position
// R15 - serial rate selectable, default 9600 Bd
// R16 - interruption counter zero or scrolling 0..255
// R17 - password gates remote parameter change
// R18 - module address selects module on bus
// R19 - dark after last register, step restarts
// R20 - measured current on three right digits
// R21 - indicator group written in third submenu
// R22 - clear records 1-5, keep comm settings
// R23 - start counters saturate at 255
`timescale 1ns/1ps
`default_nettype none
`include "efrs_map.vh"

module efrs_top #(
	parameter TICK_CYCLES   = `EFRS_CLK_HZ / 1000 * `EFRS_TICK_MS,
	parameter SCROLL_TICKS  = `EFRS_SCROLL_MS
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        rst_b,
	// switch groups
	input  wire [7:0]  function_switch_group,
	input  wire [7:0]  board_routing_switch_group,
	// stage state from the protection logic
	input  wire        low_set_stage_start,
	input  wire        low_set_stage_trip,
	input  wire        high_set_stage_start,
	input  wire        high_set_stage_trip,
	input  wire [16:0] low_set_optime_ms,
	input  wire [6:0]  high_set_time_knob,
	// measured neutral current, three bcd digits
	input  wire [11:0] meas_current,
	// external control inputs and power monitor
	input  wire [4:0]  ext_ctrl,
	input  wire        aux_power_fail,
	// front panel push-buttons, one-cycle pulses
	input  wire        step_btn,
	input  wire        reset_btn,
	input  wire        test_btn,
	input  wire        sub_btn,
	// software settings write
	input  wire        sw_wr,
	input  wire [1:0]  sw_sel,
	input  wire [1:0]  sw_submenu,
	input  wire [7:0]  sw_data,
	// serial bus side
	input  wire        comm_ok,
	input  wire        clear_records_command,
	input  wire [7:0]  bus_addr,
	input  wire [7:0]  bus_password,
	input  wire [3:0]  ser_rd_addr,
	// indicators and routed signals
	output reg  [3:0]  led,
	output reg  [2:0]  ar_start,
	output reg         block_low,
	output reg         block_high,
	output reg         remote_reset,
	output reg         ctrl_aux,
	// settings outputs
	output reg  [16:0] high_optime_ms,
	output reg  [2:0]  baud_rate,
	output reg         addr_match,
	output reg         remote_set_enable,
	output reg         trip_test_mode,
	// display and serial read data
	output reg  [15:0] disp,
	output reg  [11:0] ser_rd_data
);

	// menu positions
	localparam [3:0] M_CUR   = 4'h0;
	localparam [3:0] M_R1    = 4'h1;
	localparam [3:0] M_R2    = 4'h2;
	localparam [3:0] M_R3    = 4'h3;
	localparam [3:0] M_R4    = 4'h4;
	localparam [3:0] M_R5    = 4'h5;
	localparam [3:0] M_R0    = 4'h6;
	localparam [3:0] M_RA    = 4'h7;
	localparam [3:0] M_DARK  = 4'h8;

	// binary 0..255 to three bcd digits
	function [11:0] to_bcd;
		input [7:0] bin;
		reg   [19:0] sh;
		integer      i;
		begin
			sh = {12'h000, bin};
			for (i = 0; i < 8; i = i + 1) begin
				if (sh[11:8] > 4'h4)
					sh[11:8] = sh[11:8] + 4'h3;
				if (sh[15:12] > 4'h4)
					sh[15:12] = sh[15:12] + 4'h3;
				if (sh[19:16] > 4'h4)
					sh[19:16] = sh[19:16] + 4'h3;
				sh = {sh[18:0], 1'b0};
			end
			to_bcd = sh[19:8];
		end
	endfunction

	// state
	reg [15:0] tick_cnt_reg;
	reg        tick_reg;
	reg [7:0]  scroll_cnt_reg;
	reg [3:0]  ind_mode_reg;
	reg [3:0]  led_reg;
	reg [11:0] max_cur_reg;
	reg [7:0]  cnt_reg [0:1];
	reg [7:0]  pct_reg [0:1];
	reg [17:0] acc_reg [0:1];
	reg        trip_seen_reg [0:1];
	reg [1:0]  start_d_reg;
	reg [1:0]  trip_d_reg;
	reg [7:0]  addr_reg;
	reg [2:0]  rate_reg;
	reg [7:0]  pw_reg;
	reg [7:0]  intr_cnt_reg;
	reg [3:0]  menu_reg;
	reg [1:0]  sub_reg;
	reg        test_reg;

	// combinational helpers
	wire [1:0]  start_now = {high_set_stage_start, low_set_stage_start};
	wire [1:0]  trip_now  = {high_set_stage_trip, low_set_stage_trip};
	wire [1:0]  start_rise = start_now & ~start_d_reg;
	wire        trip_rise  = |(trip_now & ~trip_d_reg);
	wire [4:0]  ctrl_routed = ext_ctrl & board_routing_switch_group[7:3]; // R5
	wire        blk_low_w  = ctrl_routed[0] | ctrl_routed[2];
	wire        blk_high_w = ctrl_routed[1] | ctrl_routed[2];
	// both buttons together clear records and indicators instead of stepping the menu
	wire        both_btn   = step_btn & reset_btn;
	wire        clear_rec  = both_btn | clear_records_command | aux_power_fail; // R22
	wire [3:0]  ind_event  = {high_set_stage_trip, high_set_stage_start,
	                          low_set_stage_trip, low_set_stage_start};
	wire        ind_clear  = (reset_btn & ~step_btn) | ctrl_routed[3] | both_btn;
	reg  [16:0] hunit;
	reg  [16:0] optime [0:1];
	reg  [11:0] ctrl_value;
	reg  [15:0] disp_next;
	reg  [11:0] ser_next;
	reg  [3:0]  led_next;
	integer     s;
	integer     b;

	// high-set time unit from the range switch pair; 10 and 01 share a range
	always @* begin
		case ({function_switch_group[`EFRS_FSW_HTIME_HI],
		       function_switch_group[`EFRS_FSW_HTIME_LO]})
			2'b00: hunit = `EFRS_HUNIT_SHORT_MS; // R1
			2'b11: hunit = `EFRS_HUNIT_LONG_MS;  // R1
			default: hunit = `EFRS_HUNIT_MID_MS; // R1
		endcase
		optime[0] = low_set_optime_ms;
		optime[1] = hunit * {10'h000, high_set_time_knob};
	end

	// record tick divider: percentages advance in whole milliseconds
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == TICK_CYCLES[15:0] - 16'h0001) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			tick_reg     <= 1'b0;
		end
	end

	// indicators: manual bits latch, set wins over clear; others follow
	always @* begin
		for (b = 0; b < 4; b = b + 1) begin
			if (ind_mode_reg[b])
				led_next[b] = (led_reg[b] & ~ind_clear) | ind_event[b]; // R3
			else
				led_next[b] = ind_event[b]; // R2
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_b)
			led_reg <= 4'h0;
		else
			led_reg <= led_next;
	end

	// software settings; indicator group only from its submenu
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			ind_mode_reg <= `EFRS_IND_RESET; // R4
			addr_reg     <= `EFRS_ADDR_RESET;
			rate_reg     <= `EFRS_RATE_RESET; // R15
			pw_reg       <= `EFRS_PW_RESET;
		end else if (sw_wr) begin
			case (sw_sel)
				`EFRS_SEL_INDICATOR: begin
					if (sw_submenu == `EFRS_SUBMENU_IND)
						ind_mode_reg <= sw_data[3:0]; // R21
				end
				`EFRS_SEL_ADDRESS: addr_reg <= sw_data; // R18
				`EFRS_SEL_RATE: begin
					// codes above 9600 Bd are not rates; keep the old one
					if (sw_data[2:0] <= `EFRS_RATE_9600)
						rate_reg <= sw_data[2:0]; // R15
				end
				default: pw_reg <= sw_data; // R17
			endcase
		end
	end

	// maximum current; operation captures the present value
	always @(posedge ref_clk) begin
		if (!rst_b)
			max_cur_reg <= 12'h000;
		else if (clear_rec)
			max_cur_reg <= 12'h000; // R22
		else if (trip_rise)
			max_cur_reg <= meas_current; // R7
		else if (meas_current > max_cur_reg)
			max_cur_reg <= meas_current; // R7
	end

	// start counters and duration percentages for both stages
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			start_d_reg <= 2'b00;
			trip_d_reg  <= 2'b00;
			for (s = 0; s < 2; s = s + 1) begin
				cnt_reg[s]       <= 8'h00;
				pct_reg[s]       <= 8'h00;
				acc_reg[s]       <= 18'h00000;
				trip_seen_reg[s] <= 1'b0;
			end
		end else begin
			start_d_reg <= start_now;
			trip_d_reg  <= trip_now;
			for (s = 0; s < 2; s = s + 1) begin
				if (clear_rec) begin
					cnt_reg[s]       <= 8'h00; // R22
					pct_reg[s]       <= 8'h00;
					acc_reg[s]       <= 18'h00000;
					trip_seen_reg[s] <= 1'b0;
				end else begin
					if (start_rise[s] && cnt_reg[s] != 8'hFF)
						cnt_reg[s] <= cnt_reg[s] + 8'h01; // R8 R9 R23
					// a trip in the cycle of a new start still reads full scale
					if (trip_now[s]) begin
						pct_reg[s]       <= `EFRS_PCT_TRIP; // R10 R11
						trip_seen_reg[s] <= 1'b1;
					end else if (start_rise[s]) begin
						pct_reg[s]       <= 8'h00; // R10 R11
						acc_reg[s]       <= 18'h00000;
						trip_seen_reg[s] <= 1'b0;
					end else if (trip_seen_reg[s]) begin
						pct_reg[s] <= `EFRS_PCT_TRIP;
					end else if (start_now[s]) begin
						// one subtraction per cycle is ample between ms ticks
						if (tick_reg)
							acc_reg[s] <= acc_reg[s] + {1'b0, `EFRS_PCT_STEP};
						else if (optime[s] != 17'h00000 &&
						         acc_reg[s] >= {1'b0, optime[s]} &&
						         pct_reg[s] < `EFRS_PCT_RUN_MAX) begin
							acc_reg[s] <= acc_reg[s] - {1'b0, optime[s]};
							pct_reg[s] <= pct_reg[s] + 8'h01; // R10 R11
						end
					end
				end
			end
		end
	end

	// interruption counter: zero when healthy, scrolls when disturbed
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			scroll_cnt_reg <= 8'h00;
			intr_cnt_reg   <= 8'h00;
		end else if (comm_ok) begin
			scroll_cnt_reg <= 8'h00;
			intr_cnt_reg   <= 8'h00; // R16
		end else if (tick_reg) begin
			if (scroll_cnt_reg == SCROLL_TICKS[7:0] - 8'h01) begin
				scroll_cnt_reg <= 8'h00;
				intr_cnt_reg   <= intr_cnt_reg + 8'h01; // R16
			end else begin
				scroll_cnt_reg <= scroll_cnt_reg + 8'h01;
			end
		end
	end

	// display menu walk; the combined press is a clear, not a step
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			menu_reg <= M_CUR;
			sub_reg  <= 2'h0;
			test_reg <= 1'b0;
		end else begin
			if (step_btn && !reset_btn) begin
				sub_reg <= 2'h0;
				case (menu_reg)
					M_DARK: menu_reg <= M_CUR; // R19
					default: menu_reg <= menu_reg + 4'h1;
				endcase
			end else if (sub_btn && menu_reg == M_RA) begin
				sub_reg <= sub_reg + 2'h1;
			end
			if (test_btn && menu_reg == M_R0)
				test_reg <= ~test_reg; // R14
			else if (menu_reg != M_R0)
				test_reg <= 1'b0;
		end
	end

	// control register digits and display/serial selection
	always @* begin
		ctrl_value = {3'b000, remote_reset_w(ctrl_routed), `EFRS_DIGIT_ZERO,
		              2'b00, blk_high_w, blk_low_w}; // R12 R13
		case (menu_reg)
			M_CUR:  disp_next = {`EFRS_DIGIT_BLANK, meas_current}; // R20
			M_R1:   disp_next = {`EFRS_REG_MAXCUR, max_cur_reg}; // R6
			M_R2:   disp_next = {`EFRS_REG_LOWCNT, to_bcd(cnt_reg[0])};
			M_R3:   disp_next = {`EFRS_REG_HIGHCNT, to_bcd(cnt_reg[1])};
			M_R4:   disp_next = {`EFRS_REG_LOWDUR, to_bcd(pct_reg[0])};
			M_R5:   disp_next = {`EFRS_REG_HIGHDUR, to_bcd(pct_reg[1])};
			M_R0:   disp_next = {`EFRS_REG_CTRL, ctrl_value};
			M_RA: begin
				case (sub_reg)
					2'h0: disp_next = {`EFRS_REG_COMM, to_bcd(addr_reg)};
					2'h1: disp_next = {`EFRS_REG_COMM, 9'h000, rate_reg};
					2'h2: disp_next = {`EFRS_REG_COMM, to_bcd(intr_cnt_reg)};
					default: disp_next = {`EFRS_REG_COMM, to_bcd(pw_reg)};
				endcase
			end
			default: disp_next = {4{`EFRS_DIGIT_BLANK}}; // R19
		endcase
		case (ser_rd_addr)
			`EFRS_REG_CTRL:    ser_next = ctrl_value;
			`EFRS_REG_MAXCUR:  ser_next = max_cur_reg;
			`EFRS_REG_LOWCNT:  ser_next = to_bcd(cnt_reg[0]);
			`EFRS_REG_HIGHCNT: ser_next = to_bcd(cnt_reg[1]);
			`EFRS_REG_LOWDUR:  ser_next = to_bcd(pct_reg[0]);
			`EFRS_REG_HIGHDUR: ser_next = to_bcd(pct_reg[1]);
			`EFRS_REG_COMM:    ser_next = to_bcd(addr_reg);
			default:           ser_next = 12'h000;
		endcase
	end

	// remote reset digit of the control register, taken from routed control input 3
	function remote_reset_w;
		input [4:0] routed;
		begin
			remote_reset_w = routed[3];
		end
	endfunction

	// registered outputs
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			led               <= 4'h0;
			ar_start          <= 3'h0;
			block_low         <= 1'b0;
			block_high        <= 1'b0;
			remote_reset      <= 1'b0;
			ctrl_aux          <= 1'b0;
			high_optime_ms    <= 17'h00000;
			baud_rate         <= `EFRS_RATE_RESET;
			addr_match        <= 1'b0;
			remote_set_enable <= 1'b0;
			trip_test_mode    <= 1'b0;
			disp              <= {4{`EFRS_DIGIT_BLANK}};
			ser_rd_data       <= 12'h000;
		end else begin
			led               <= led_reg;
			ar_start          <= board_routing_switch_group[2:0] &
			                     {low_set_stage_start | high_set_stage_start,
			                      high_set_stage_start, low_set_stage_start}; // R5
			block_low         <= blk_low_w; // R5
			block_high        <= blk_high_w;
			remote_reset      <= ctrl_routed[3];
			ctrl_aux          <= ctrl_routed[4];
			high_optime_ms    <= optime[1]; // R1
			baud_rate         <= rate_reg; // R15
			addr_match        <= (bus_addr == addr_reg); // R18
			remote_set_enable <= (bus_addr == addr_reg) && (bus_password == pw_reg); // R17
			trip_test_mode    <= test_reg; // R14
			disp              <= disp_next; // R6
			ser_rd_data       <= ser_next;
		end
	end

endmodule
`default_nettype wire

/* dv/efrs_monitor.sv */
// assertion checker of the earth-fault recorder settings block
`timescale 1ns/1ps
`default_nettype none
module efrs_monitor (
	// clock, reset and inputs
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic [7:0]  function_switch_group,
	input wire logic [7:0]  board_routing_switch_group,
	input wire logic        low_set_stage_start,
	input wire logic        low_set_stage_trip,
	input wire logic        high_set_stage_start,
	input wire logic [6:0]  high_set_time_knob,
	input wire logic [4:0]  ext_ctrl,
	input wire logic        aux_power_fail,
	input wire logic        step_btn,
	input wire logic        reset_btn,
	input wire logic        sw_wr,
	input wire logic [1:0]  sw_sel,
	input wire logic [7:0]  sw_data,
	input wire logic        clear_records_command,
	input wire logic [3:0]  ser_rd_addr,
	// outputs
	input wire logic [2:0]  ar_start,
	input wire logic        block_low,
	input wire logic        block_high,
	input wire logic        remote_reset,
	input wire logic        ctrl_aux,
	input wire logic [16:0] high_optime_ms,
	input wire logic [2:0]  baud_rate,
	input wire logic [15:0] disp,
	input wire logic [11:0] ser_rd_data
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic [2:0] ch;
	// expected routing and high-set time, recent clear history
	wire [4:0]  rt = ext_ctrl & board_routing_switch_group[7:3];
	wire [12:0] cs = {ext_ctrl, board_routing_switch_group};
	wire [9:0]  as = {low_set_stage_start, high_set_stage_start, board_routing_switch_group};
	wire [2:0]  ax = {low_set_stage_start | high_set_stage_start, high_set_stage_start,
		low_set_stage_start} & board_routing_switch_group[2:0];
	wire [1:0]  rg = function_switch_group[7:6];
	wire [16:0] hu = (rg == 2'h0) ? 17'h0000A : (rg == 2'h3) ? 17'h003E8 : 17'h00064;
	wire [16:0] hx = {10'h000, high_set_time_knob} * hu;
	wire        cl = clear_records_command | aux_power_fail | (step_btn & reset_btn);
	wire        qt = !cl && (ch == 3'h0);
	// a clear may land a few cycles late, so records are judged only when quiet
	always @(posedge ref_clk) begin
		if (!rst_b)
			ch <= 3'h0;
		else
			ch <= {ch[1:0], cl};
	end
	a_rate_take: assert property (
		sw_wr && sw_sel == 2'h2 && sw_data <= 8'h04 |-> ##2 {5'h00, baud_rate} == $past(sw_data, 2))
		else $error("rate write not applied");
	a_reset_out: assert property (@(posedge ref_clk) disable iff (1'b0)
		!rst_b |=> baud_rate == 3'h4 && disp == 16'hFFFF) else $error("reset outputs wrong");
	a_htime_range: assert property (
		(rst_b && $stable(function_switch_group) && $stable(high_set_time_knob))[*3]
		|-> high_optime_ms == hx) else $error("high-set time wrong");
	a_block_route: assert property (
		(rst_b && $stable(cs))[*3]
		|-> {ctrl_aux, block_high, block_low, remote_reset} ==
			{rt[4], rt[1] | rt[2], rt[0] | rt[2], rt[3]})
		else $error("control routing wrong");
	a_ar_route: assert property (
		(rst_b && $stable(as))[*3] |-> ar_start == ax) else $error("reclose routing wrong");
	a_ctrl_digits: assert property (
		(rst_b && ser_rd_addr == 4'h0 && $stable(cs))[*3]
		|-> ser_rd_data == {3'h0, rt[3], 6'h00, rt[1] | rt[2], rt[0] | rt[2]})
		else $error("control register digits wrong");
	a_clear_wins: assert property (
		clear_records_command ##1 (ser_rd_addr == 4'h2 && !low_set_stage_start)[*3]
		|-> ser_rd_data == 12'h000) else $error("records not cleared");
	a_count_hold: assert property (
		(ser_rd_addr == 4'h3 && ser_rd_data == 12'h255 && qt) ##1 (ser_rd_addr == 4'h3 && qt)
		|=> ser_rd_data == 12'h255) else $error("start counter left full scale");
	a_trip_pct: assert property (
		(rst_b && low_set_stage_trip && $stable(low_set_stage_start) && ser_rd_addr == 4'h4 && qt)[*4]
		|-> ser_rd_data == 12'h100) else $error("trip duration not full scale");
	c_rate: cover property (sw_wr && sw_sel == 2'h2);
	c_clear: cover property (clear_records_command);
	c_full: cover property (ser_rd_addr == 4'h3 && ser_rd_data == 12'h255);
endmodule
bind efrs_top efrs_monitor efrs_monitor_i (.*);
`default_nettype wire

/* dv/efrs_comm_model.sv */
// serial-side communicator model feeding the recorder block
`timescale 1ns/1ps
`default_nettype none
module efrs_comm_model (
	// clock and bench requests
	input  wire logic       ref_clk,
	input  wire logic       up,
	input  wire logic       clr,
	input  wire logic       rd_go,
	input  wire logic [3:0] rd_a,
	input  wire logic [7:0] ba,
	input  wire logic [7:0] bp,
	// lines toward the block
	output logic            comm_ok,
	output logic            clear_records_command,
	output logic [3:0]      ser_rd_addr,
	output logic [7:0]      bus_addr,
	output logic [7:0]      bus_password
);
	logic       clr_d = 1'b0;
	logic [3:0] last = 4'h0;
	// clear goes out as one cycle whatever the request length
	always @(posedge ref_clk) begin
		clr_d <= clr;
		if (rd_go)
			last <= rd_a;
	end
	// idle address shows the inverse of the last one, never a stale copy
	assign clear_records_command = clr & ~clr_d;
	assign ser_rd_addr = rd_go ? rd_a : ~last;
	assign comm_ok = up;
	assign bus_addr = ba;
	assign bus_password = bp;
endmodule
`default_nettype wire

/* dv/efrs_top_tb.sv */
// self-checking bench of the earth-fault recorder settings block
`timescale 1ns/1ps
`default_nettype none
module efrs_top_tb;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  fsw = 8'h00;
	logic [7:0]  brd = 8'hFF;
	logic [3:0]  ev = 4'h0;
	logic [3:0]  btn = 4'h0;
	logic [11:0] meas = 12'h000;
	logic [4:0]  ext = 5'h00;
	logic        wr = 1'b0;
	logic [1:0]  sel = 2'h0;
	logic [1:0]  sub = 2'h0;
	logic [7:0]  dat = 8'h00;
	logic        clr = 1'b0;
	logic        go = 1'b0;
	logic [3:0]  ra = 4'h0;
	logic [7:0]  ba = 8'h00;
	logic [7:0]  bp = 8'h00;
	logic        lnk = 1'b1;
	logic        apf = 1'b0;
	logic        pend = 1'b0;
	logic [18:0] q[$];
	logic [18:0] nt;
	logic [15:0] got;
	logic [7:0]  seed = 8'h04;
	logic [4:0]  rt;
	logic [3:0]  dig [0:7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h0, 4'hA, 4'hF};
	integer      i;
	integer      k;
	integer      err_total = 0;
	integer      n_compared = 0;
	wire [3:0]   led;
	wire [16:0]  hot;
	wire [2:0]   baud;
	wire         am, rse, ttm, cok, clc;
	wire [15:0]  disp;
	wire [11:0]  rdd;
	wire [3:0]   sra;
	wire [7:0]   bad, bpw;
	// short tick counts keep records moving in a short run
	efrs_top #(.TICK_CYCLES(10), .SCROLL_TICKS(2)) efrs_top_i (.ref_clk(ref_clk), .rst_b(rst_b),
		.function_switch_group(fsw), .board_routing_switch_group(brd),
		.low_set_stage_start(ev[0]), .low_set_stage_trip(ev[1]),
		.high_set_stage_start(ev[2]), .high_set_stage_trip(ev[3]),
		.low_set_optime_ms(17'h003E8), .high_set_time_knob(7'h05), .meas_current(meas),
		.ext_ctrl(ext), .aux_power_fail(apf), .step_btn(btn[0]), .reset_btn(btn[1]),
		.test_btn(btn[2]), .sub_btn(btn[3]), .sw_wr(wr), .sw_sel(sel), .sw_submenu(sub),
		.sw_data(dat), .comm_ok(cok), .clear_records_command(clc), .bus_addr(bad),
		.bus_password(bpw), .ser_rd_addr(sra), .led(led), .ar_start(), .block_low(),
		.block_high(), .remote_reset(), .ctrl_aux(), .high_optime_ms(hot), .baud_rate(baud),
		.addr_match(am), .remote_set_enable(rse), .trip_test_mode(ttm), .disp(disp),
		.ser_rd_data(rdd));
	efrs_comm_model efrs_comm_model_i (.ref_clk(ref_clk), .up(lnk), .clr(clr), .rd_go(go),
		.rd_a(ra), .ba(ba), .bp(bp), .comm_ok(cok), .clear_records_command(clc),
		.ser_rd_addr(sra), .bus_addr(bad), .bus_password(bpw));
	always #12.5 ref_clk = ~ref_clk;
	function automatic [7:0] lfsr(input [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task conclude;
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wt(input integer n);
		repeat (n) @(negedge ref_clk);
	endtask
	// note an expectation; the watcher takes it at the next rising edge
	task automatic expq(input [2:0] k, input [15:0] e);
		q.push_back({k, e});
		pend = 1'b1;
		wt(1);
		pend = 1'b0;
	endtask
	task automatic rd(input [3:0] a, input [11:0] e);
		ra = a;
		go = 1'b1;
		wt(3);
		expq(3'h0, {4'h0, e});
		go = 1'b0;
	endtask
	task automatic pe(input [3:0] m, input integer n);
		ev = m;
		wt(n);
		ev = 4'h0;
		wt(3);
	endtask
	task automatic pb(input [3:0] m);
		btn = m;
		wt(1);
		btn = 4'h0;
		wt(2);
	endtask
	task automatic sw(input [1:0] s, input [1:0] u, input [7:0] d);
		sel = s;
		sub = u;
		dat = d;
		wr = 1'b1;
		wt(1);
		wr = 1'b0;
		wt(2);
	endtask
	// oldest note is compared with the output its kind names
	always @(posedge ref_clk) begin
		if (pend) begin
			nt = q.pop_front();
			case (nt[18:16])
			3'h0: got = {4'h0, rdd};
			3'h1: got = disp;
			3'h2: got = {13'h0000, baud};
			3'h3: got = hot[15:0];
			3'h4: got = {12'h000, led};
			3'h5: got = {13'h0000, am, rse, ttm};
			3'h6: got = {12'h000, disp[15:12]};
			default: got = {4'h0, disp[11:0]};
			endcase
			n_compared++;
			if (got !== nt[15:0]) begin
				err_total++;
				$display("[FAIL] %0t kind %0d got %h exp %h", $time, nt[18:16], got, nt[15:0]);
			end
		end
	end
	initial begin
		#500000;
		err_total++;
		conclude();
	end
	initial begin
		wt(10);
		rst_b = 1'b1;
		wt(2);
		expq(3'h2, 16'h0004);
		for (i = 0; i < 6; i++) begin
			sw(2'h2, 2'h0, i[7:0]);
			expq(3'h2, (i < 5) ? i[15:0] : 16'h0004);
		end
		for (i = 0; i < 4; i++) begin
			fsw[7:6] = i[1:0];
			wt(3);
			expq(3'h3, (i == 0) ? 16'h0032 : (i == 3) ? 16'h1388 : 16'h01F4);
		end
		fsw = 8'h00;
		pe(4'h1, 2);
		expq(3'h4, 16'h0000);
		sw(2'h0, 2'h0, 8'h00);
		pe(4'h2, 2);
		expq(3'h4, 16'h0002);
		pb(4'h2);
		expq(3'h4, 16'h0000);
		sw(2'h0, 2'h3, 8'h0F);
		pe(4'h1, 2);
		expq(3'h4, 16'h0001);
		meas = 12'h123;
		wt(3);
		meas = 12'h050;
		rd(4'h1, 12'h123);
		meas = 12'h040;
		pe(4'h2, 2);
		rd(4'h1, 12'h040);
		repeat (3) pe(4'h1, 1);
		rd(4'h2, 12'h005);
		repeat (260) pe(4'h4, 1);
		rd(4'h3, 12'h255);
		ev = 4'h1;
		wt(4);
		ev = 4'h3;
		rd(4'h4, 12'h100);
		ev = 4'h0;
		wt(2);
		ev = 4'h1;
		rd(4'h4, 12'h000);
		ev = 4'h4;
		wt(2);
		ev = 4'hC;
		rd(4'h5, 12'h100);
		pe(4'h0, 1);
		// no current, so the cleared maximum is not refilled at once
		meas = 12'h000;
		clr = 1'b1;
		wt(1);
		clr = 1'b0;
		for (i = 2; i < 7; i++)
			rd((i == 6) ? 4'h1 : i[3:0], 12'h000);
		pe(4'h4, 1);
		apf = 1'b1;
		wt(1);
		apf = 1'b0;
		rd(4'h3, 12'h000);
		pe(4'h1, 1);
		pb(4'h3);
		rd(4'h2, 12'h000);
		meas = 12'h321;
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			ext = seed[4:0];
			seed = lfsr(seed);
			brd = seed;
			rt = ext & brd[7:3];
			rd(4'h0, {3'h0, rt[3], 6'h00, rt[1] | rt[2], rt[0] | rt[2]});
		end
		ext = 5'h00;
		brd = 8'hFF;
		pb(4'h4);
		expq(3'h5, 16'h0000);
		for (i = 0; i < 8; i++) begin
			pb(4'h1);
			expq(3'h6, {12'h000, dig[i]});
			if (i == 1)
				expq(3'h1, 16'h2000);
			if (i == 6) begin
				expq(3'h1, 16'hA001);
				pb(4'h8);
				expq(3'h1, 16'hA004);
				pb(4'h8);
				expq(3'h1, 16'hA000);
				// link down: wait for the first scroll step of the counter
				lnk = 1'b0;
				for (k = 0; k < 60 && disp[11:0] == 12'h000; k++)
					wt(1);
				expq(3'h7, 16'h0001);
				lnk = 1'b1;
				wt(2);
				expq(3'h7, 16'h0000);
			end
			if (i == 5) begin
				pb(4'h4);
				expq(3'h5, 16'h0001);
			end
		end
		pb(4'h1);
		expq(3'h7, {4'h0, meas});
		sw(2'h1, 2'h0, 8'h12);
		ba = 8'h12;
		bp = 8'h34;
		wt(2);
		expq(3'h5, 16'h0004);
		sw(2'h3, 2'h0, 8'h34);
		expq(3'h5, 16'h0006);
		conclude();
	end
endmodule
`default_nettype wire
